/* File: verilog/eyq_rx_diag.sv */
// Purpose: Receiver eye-scan engine and equalizer freeze with cursor analysis
// Assumes: Link symbols arrive on mclk from same-clock logic
// Notes: Cursor analysis and adaptation watch lane 0 only
// How it works
// - Scan all enabled lanes together, any bitstream
// - Mode below 8 uses programmed offset, else auto
// - Sampler timing tap follows programmed phase offset
// - Analyze one bit per twenty, selected position
// - Run ends after programmed sample count
// - Clear pulse zeroes counter, else accumulates
// - Run control high starts collection
// - Per-lane done rises when run completes
// - Auto modes report boundary, others report count
// - Runs repeat with receiver left enabled
// - Receiver adapts in mode 1 before analysis
// - Freeze stops adaptation, forces flags low
// - Freeze change acted on within 48 UI
// - Mode 2 pre-cursor, mode 3 post-cursor analysis
// - Analysis completes within 150000 UI
// - Flags report over or under equalization
// - Mode change and freeze release written separately
// - Mode 1 then freeze release resumes adaptation
`timescale 1ns/1ps
module eyq_rx_diag #(
  parameter int LANES = eyq_pkg::LANES_DEF,
  parameter int ANALYSIS_CYC = eyq_pkg::ANALYSIS_CYC_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  eyq_link_if.rx lk,
  input wire logic link_receiver_enable,
  input wire logic [LANES-1:0] lane_enable,
  input wire logic [eyq_pkg::MODE_W-1:0] scan_mode_select,
  input wire logic [eyq_pkg::VO_W-1:0] sampler_voltage_offset,
  input wire logic [eyq_pkg::PO_W-1:0] sampler_phase_offset,
  input wire logic [eyq_pkg::DECIM_W-1:0] decimation_phase_select,
  input wire logic [eyq_pkg::LEN_W-1:0] scan_sample_length,
  input wire logic mismatch_counter_clear,
  input wire logic scan_run_control,
  input wire logic [eyq_pkg::EQM_W-1:0] equalizer_mode,
  input wire logic equalizer_freeze,
  output logic [LANES-1:0] scan_done_flag,
  output logic [LANES-1:0][eyq_pkg::CNT_W-1:0] mismatch_counter,
  output logic [LANES-1:0][eyq_pkg::VO_W-1:0] eye_boundary_readback,
  output logic [eyq_pkg::EQ_W-1:0] equalizer_level_readback,
  output logic over_equalized_flag,
  output logic under_equalized_flag
);
  import eyq_pkg::*;

  logic [DECIM_W-1:0] dec_q, dec_d;
  logic [LANES-1:0][TAPS-1:0][LVL_W-1:0] lvl_q, lvl_d;
  logic [LANES-1:0][TAPS-1:0] bit_q, bit_d;
  logic run_q, run_d, clr_q, clr_d;
  logic [LANES-1:0] done_q, done_d;
  logic [LANES-1:0][LEN_W-1:0] sc_q, sc_d;
  logic [LANES-1:0][CNT_W-1:0] cnt_q, cnt_d;
  logic [LANES-1:0][VO_W-1:0] bnd_q, bnd_d;
  logic [LEN_W-1:0] target;

  assign target = (scan_sample_length == '0) ? LEN_W'(1) : scan_sample_length;

  // Scan engine
  always_comb
  begin
    logic [LVL_W-1:0] samp;
    logic [LVL_W-1:0] mag;
    logic signed [LVL_W:0] diff;
    logic miss;
    logic take;
    samp = '0;
    mag = '0;
    diff = '0;
    miss = 1'b0;
    take = 1'b0;
    dec_d = dec_q;
    lvl_d = lvl_q;
    bit_d = bit_q;
    done_d = done_q;
    sc_d = sc_q;
    cnt_d = cnt_q;
    bnd_d = bnd_q;
    run_d = scan_run_control;
    clr_d = mismatch_counter_clear;
    if (link_receiver_enable && lk.valid)
    begin
      dec_d = (dec_q == DECIM_W'(DECIM - 1)) ? '0 : dec_q + DECIM_W'(1);
    end
    for (int l = 0; l < LANES; l++)
    begin
      if (lk.valid)
      begin
        lvl_d[l] = {lvl_q[l][TAPS-2:0], lk.lane_level[l]};
        bit_d[l] = {bit_q[l][TAPS-2:0], lk.lane_bit[l]};
      end
      samp = lvl_q[l][sampler_phase_offset];
      mag = samp[LVL_W-1] ? LVL_W'(-samp) : samp;
      diff = $signed({samp[LVL_W-1], samp}) -
        $signed({sampler_voltage_offset[VO_W-1], sampler_voltage_offset});
      miss = (diff >= 0) != bit_q[l][TAP_REF];
      take = scan_run_control && run_q && !done_q[l] && lane_enable[l] &&
        link_receiver_enable && lk.valid && (dec_q == decimation_phase_select);
      if (clr_q && !mismatch_counter_clear)
      begin
        cnt_d[l] = '0;
      end
      if (take && (scan_mode_select < MODE_AUTO_MIN))
      begin
        cnt_d[l] = cnt_d[l] + CNT_W'((scan_mode_select == MODE_MATCH) ? !miss : miss);
      end
      if (take && (scan_mode_select >= MODE_AUTO_MIN))
      begin
        case (scan_mode_select)
          MODE_INNER: if (mag < bnd_q[l]) bnd_d[l] = mag;
          MODE_OUTER: if (mag > bnd_q[l]) bnd_d[l] = mag;
          MODE_AVERAGE: bnd_d[l] = VO_W'(({1'b0, bnd_q[l]} + {1'b0, mag}) >> 1);
          default: bnd_d[l] = bnd_q[l];
        endcase
      end
      if (take)
      begin
        sc_d[l] = sc_q[l] + LEN_W'(1);
        if (sc_q[l] + LEN_W'(1) >= target)
        begin
          done_d[l] = 1'b1;
        end
      end
      if (scan_run_control && !run_q)
      begin
        sc_d[l] = '0;
        bnd_d[l] = (scan_mode_select == MODE_INNER) ? BND_INNER_RST : BND_OUTER_RST;
      end
      if (!scan_run_control)
      begin
        done_d[l] = 1'b0;
        sc_d[l] = '0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      dec_q <= '0;
      lvl_q <= '0;
      bit_q <= '0;
      run_q <= 1'b0;
      clr_q <= 1'b0;
      done_q <= '0;
      sc_q <= '0;
      cnt_q <= '0;
      bnd_q <= '0;
    end
    else
    begin
      dec_q <= dec_d;
      lvl_q <= lvl_d;
      bit_q <= bit_d;
      run_q <= run_d;
      clr_q <= clr_d;
      done_q <= done_d;
      sc_q <= sc_d;
      cnt_q <= cnt_d;
      bnd_q <= bnd_d;
    end
  end

  assign scan_done_flag = done_q;
  assign mismatch_counter = cnt_q;
  assign eye_boundary_readback = bnd_q;

  // Equalizer freeze and cursor analysis
  eyq_eq_t st_q, st_d;
  logic frz_q, frz_d;
  logic [EQ_W-1:0] eq_q, eq_d;
  logic [ADC_W-1:0] adc_q, adc_d;
  logic signed [ACC_W-1:0] acc_q, acc_d;
  logic [AN_W-1:0] an_q, an_d;
  logic over_q, over_d, under_q, under_d;

  always_comb
  begin
    logic [LVL_W-1:0] c;
    logic [LVL_W-1:0] m;
    logic big;
    logic pre_tr;
    logic post_tr;
    logic live;
    c = lvl_q[0][TAP_REF];
    m = c[LVL_W-1] ? LVL_W'(-c) : c;
    big = m > EQ_TARGET;
    pre_tr = bit_q[0][TAP_REF-1] != bit_q[0][TAP_REF];
    post_tr = bit_q[0][TAP_REF+1] != bit_q[0][TAP_REF];
    live = lk.valid && link_receiver_enable;
    st_d = st_q;
    eq_d = eq_q;
    adc_d = adc_q;
    acc_d = acc_q;
    an_d = an_q;
    over_d = 1'b0;
    under_d = 1'b0;
    frz_d = equalizer_freeze;
    case (st_q)
      EQ_ADAPT:
      begin
        if (frz_q)
        begin
          st_d = EQ_HOLD;
        end
        else if (live && post_tr && (equalizer_mode == EQM_ADAPT))
        begin
          adc_d = adc_q + ADC_W'(1);
          if (adc_q == '1)
          begin
            if (big && (eq_q != '0)) eq_d = eq_q - EQ_W'(1);
            if (!big && (eq_q != '1)) eq_d = eq_q + EQ_W'(1);
          end
        end
      end
      EQ_HOLD:
      begin
        if (!frz_q && (equalizer_mode == EQM_ADAPT))
        begin
          st_d = EQ_ADAPT;
        end
        else if (!frz_q && (equalizer_mode >= EQM_PRE))
        begin
          st_d = EQ_ANALYZE;
          acc_d = '0;
          an_d = '0;
        end
      end
      EQ_ANALYZE:
      begin
        an_d = an_q + AN_W'(1);
        if (live && ((equalizer_mode == EQM_PRE) ? pre_tr : post_tr))
        begin
          acc_d = big ? acc_q + ACC_W'(1) : acc_q - ACC_W'(1);
        end
        if (frz_q)
        begin
          st_d = EQ_HOLD;
        end
        // Two cycles of freeze and state latency included
        else if (an_q == AN_W'(ANALYSIS_CYC - 3))
        begin
          st_d = EQ_RESULT;
          over_d = acc_d > 0;
          under_d = acc_d < 0;
        end
      end
      EQ_RESULT:
      begin
        over_d = over_q;
        under_d = under_q;
        if (frz_q)
        begin
          st_d = EQ_HOLD;
          over_d = 1'b0;
          under_d = 1'b0;
        end
      end
      default: st_d = EQ_HOLD;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q <= EQ_ADAPT;
      frz_q <= 1'b0;
      eq_q <= EQ_LEVEL_RST;
      adc_q <= '0;
      acc_q <= '0;
      an_q <= '0;
      over_q <= 1'b0;
      under_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      frz_q <= frz_d;
      eq_q <= eq_d;
      adc_q <= adc_d;
      acc_q <= acc_d;
      an_q <= an_d;
      over_q <= over_d;
      under_q <= under_d;
    end
  end

  assign equalizer_level_readback = eq_q;
  assign over_equalized_flag = over_q;
  assign under_equalized_flag = under_q;
endmodule

/* File: verilog/eyq_pkg.sv */
// Purpose: Shared constants and types for the eye-scan and cursor analysis link pair
// Assumes: One link bit per lane per mclk cycle, so one UI is one mclk period
// Notes: Levels are signed two's complement receiver amplitudes
package eyq_pkg;
  localparam int LANES_DEF = 2;
  localparam int LVL_W = 8;
  localparam int CNT_W = 24;
  localparam int LEN_W = 16;
  localparam int VO_W = 8;
  localparam int MODE_W = 4;
  localparam int PO_W = 2;
  localparam int TAPS = 4;
  localparam int TAP_REF = 1;
  localparam int DECIM = 20;
  localparam int DECIM_W = 5;
  localparam int EQM_W = 2;
  localparam int EQ_W = 5;
  localparam int ACC_W = 20;
  localparam int AN_W = 20;
  localparam int ADC_W = 4;
  localparam int EMPH_W = 4;
  localparam logic [MODE_W-1:0] MODE_MATCH = 4'h1;
  localparam logic [MODE_W-1:0] MODE_AUTO_MIN = 4'h8;
  localparam logic [MODE_W-1:0] MODE_INNER = 4'h8;
  localparam logic [MODE_W-1:0] MODE_OUTER = 4'h9;
  localparam logic [MODE_W-1:0] MODE_AVERAGE = 4'hA;
  localparam logic [EQM_W-1:0] EQM_ADAPT = 2'h1;
  localparam logic [EQM_W-1:0] EQM_PRE = 2'h2;
  localparam logic [EQM_W-1:0] EQM_POST = 2'h3;
  localparam logic [EQ_W-1:0] EQ_LEVEL_RST = 5'h10;
  localparam logic [LVL_W-1:0] EQ_TARGET = 8'h28;
  localparam logic [VO_W-1:0] BND_INNER_RST = 8'h7F;
  localparam logic [VO_W-1:0] BND_OUTER_RST = 8'h00;
  localparam logic [6:0] LFSR_SEED = 7'h7F;
  localparam int TX_AMP = 40;
  localparam int TX_ISI = 12;
  // Timing in unit intervals and the derived cycle counts
  localparam int CLK_NS = 40;
  localparam int UI_NS = 40;
  localparam int FREEZE_ACT_UI = 48;
  localparam int FREEZE_ACT_CYC = (FREEZE_ACT_UI * UI_NS) / CLK_NS;
  localparam int ANALYSIS_UI = 150000;
  localparam int ANALYSIS_CYC_DEF = (ANALYSIS_UI * UI_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0]
  {
    EQ_ADAPT = 2'b00,
    EQ_HOLD = 2'b01,
    EQ_ANALYZE = 2'b10,
    EQ_RESULT = 2'b11
  } eyq_eq_t;
endpackage

/* File: verilog/eyq_link_if.sv */
// Purpose: Serial lane bundle between transmitter end and receiver diagnostic end
// Assumes: Both ends share mclk; one symbol per lane per cycle when valid
// Notes: Level is the received amplitude, bit is the transmitted reference
`timescale 1ns/1ps
interface eyq_link_if #(parameter int LANES = eyq_pkg::LANES_DEF);
  logic valid;
  logic [LANES-1:0] lane_bit;
  logic [LANES-1:0][eyq_pkg::LVL_W-1:0] lane_level;
  modport tx (output valid, output lane_bit, output lane_level);
  modport rx (input valid, input lane_bit, input lane_level);
endinterface

/* File: verilog/eyq_tx_end.sv */
// Purpose: Serial link transmitter end driving pattern bits and lane levels
// Assumes: One symbol per lane per mclk cycle while enabled
// Notes: Level carries a post-cursor term reduced by pre-emphasis
`timescale 1ns/1ps
module eyq_tx_end #(
  parameter int LANES = eyq_pkg::LANES_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  eyq_link_if.tx lk,
  input wire logic tx_enable,
  input wire logic pattern_select,
  input wire logic [eyq_pkg::EMPH_W-1:0] pre_emphasis
);
  import eyq_pkg::*;

  logic [LANES-1:0][6:0] lfsr_q, lfsr_d;
  logic [LANES-1:0] bit_q, bit_d;
  logic [LANES-1:0][LVL_W-1:0] lvl_q, lvl_d;
  logic valid_q, valid_d;

  // Pattern and level generation
  always_comb
  begin
    logic nb;
    int lv;
    nb = 1'b0;
    lv = 0;
    lfsr_d = lfsr_q;
    bit_d = bit_q;
    lvl_d = lvl_q;
    valid_d = tx_enable;
    for (int l = 0; l < LANES; l++)
    begin
      if (tx_enable)
      begin
        nb = pattern_select ? !bit_q[l] : (lfsr_q[l][6] ^ lfsr_q[l][5]);
        lfsr_d[l] = {lfsr_q[l][5:0], lfsr_q[l][6] ^ lfsr_q[l][5]};
        lv = (nb ? TX_AMP : -TX_AMP) +
          (bit_q[l] ? 1 : -1) * (TX_ISI - int'(pre_emphasis));
        bit_d[l] = nb;
        lvl_d[l] = LVL_W'(lv);
      end
      else
      begin
        lvl_d[l] = '0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lfsr_q <= {LANES{LFSR_SEED}};
      bit_q <= '0;
      lvl_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      lfsr_q <= lfsr_d;
      bit_q <= bit_d;
      lvl_q <= lvl_d;
      valid_q <= valid_d;
    end
  end

  assign lk.valid = valid_q;
  assign lk.lane_bit = bit_q;
  assign lk.lane_level = lvl_q;
endmodule

/* File: dv/eyq_chk.sv */
// Purpose: Assertions on eye-scan and equalizer outputs
// Assumes: One mclk domain, lane 0 stands for all lanes
// Notes: Instantiated beside the link interface
`timescale 1ns/1ps
module eyq_chk #(
  parameter int LANES = eyq_pkg::LANES_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic valid,
  input wire logic link_receiver_enable,
  input wire logic [eyq_pkg::MODE_W-1:0] scan_mode_select,
  input wire logic [eyq_pkg::LEN_W-1:0] scan_sample_length,
  input wire logic mismatch_counter_clear,
  input wire logic scan_run_control,
  input wire logic equalizer_freeze,
  input wire logic [LANES-1:0] scan_done_flag,
  input wire logic [LANES-1:0][eyq_pkg::CNT_W-1:0] mismatch_counter,
  input wire logic [eyq_pkg::EQ_W-1:0] equalizer_level_readback,
  input wire logic over_equalized_flag,
  input wire logic under_equalized_flag
);
  import eyq_pkg::*;
  int sym_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Symbols seen since the run began
  always_ff @(posedge mclk)
  begin
    if (reset || !scan_run_control)
      sym_q <= 0;
    else if (valid && link_receiver_enable)
      sym_q <= sym_q + 1;
  end
  property p_done_clr;
    !scan_run_control |=> scan_done_flag == '0;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");
  property p_len_min;
    $rose(scan_done_flag[0]) |-> sym_q + 20 >= 20 * int'(scan_sample_length);
  endproperty
  a_len_min: assert property (p_len_min) else $error("run ended early");
  property p_len_max;
    scan_run_control && !scan_done_flag[0] |-> sym_q <= 20 * int'(scan_sample_length) + 20;
  endproperty
  a_len_max: assert property (p_len_max) else $error("run ended late");
  property p_clr;
    $fell(mismatch_counter_clear) |-> ##[1:2] mismatch_counter[0] <= 24'h1;
  endproperty
  a_clr: assert property (p_clr) else $error("counter not zeroed");
  property p_auto_hold;
    (scan_mode_select >= 4'h8 && !mismatch_counter_clear)[*3] |=> $stable(mismatch_counter);
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("counter moved");
  property p_frz_flags;
    equalizer_freeze[*4] |-> !over_equalized_flag && !under_equalized_flag;
  endproperty
  a_frz_flags: assert property (p_frz_flags) else $error("flags high when frozen");
  property p_frz_lat;
    $rose(equalizer_freeze) |-> ##[1:48] (!over_equalized_flag && !under_equalized_flag);
  endproperty
  a_frz_lat: assert property (p_frz_lat) else $error("freeze not acted on");
  property p_frz_lvl;
    equalizer_freeze[*4] |=> $stable(equalizer_level_readback);
  endproperty
  a_frz_lvl: assert property (p_frz_lvl) else $error("level adapted when frozen");
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the link pair
// Assumes: Analysis shortened to 200 cycles
// Notes: Driver queues notes, monitor compares
`timescale 1ns/1ps
module tb_top;
  import eyq_pkg::*;
  typedef struct packed {logic [1:0] kind; logic [CNT_W-1:0] val;} eyq_note_t;
  logic mclk = 0;
  logic reset = 1;
  logic rx_en = 0;
  logic tx_en = 0;
  logic pat = 0;
  logic clr = 0;
  logic run = 0;
  logic frz = 0;
  logic done_p = 0;
  logic flg_p = 0;
  logic [1:0] lane_en = 2'h3;
  logic [EMPH_W-1:0] pe = 4'hC;
  logic [MODE_W-1:0] mode = 4'h0;
  logic [VO_W-1:0] vo = 8'h00;
  logic [PO_W-1:0] po = 2'h1;
  logic [DECIM_W-1:0] dsel = 5'h00;
  logic [LEN_W-1:0] slen = 16'h0008;
  logic [EQM_W-1:0] eqm = 2'h0;
  logic [CNT_W-1:0] acc = 24'h0;
  logic [31:0] rs = 32'h000132C5;
  logic [1:0] done;
  logic [1:0][CNT_W-1:0] cnt;
  logic [1:0][VO_W-1:0] bnd;
  logic [EQ_W-1:0] lvl;
  logic ovr;
  logic und;
  int n_errors = 0;
  int check_count = 0;
  eyq_note_t notes[$];
  initial forever #20 mclk = ~mclk;
  eyq_link_if #(.LANES(2)) i_eyq_link_if ();
  eyq_tx_end #(.LANES(2)) i_eyq_tx_end (.mclk(mclk), .reset(reset), .lk(i_eyq_link_if),
    .tx_enable(tx_en), .pattern_select(pat), .pre_emphasis(pe));
  eyq_rx_diag #(.LANES(2), .ANALYSIS_CYC(200)) i_eyq_rx_diag (.mclk(mclk), .reset(reset),
    .lk(i_eyq_link_if), .link_receiver_enable(rx_en), .lane_enable(lane_en),
    .scan_mode_select(mode), .sampler_voltage_offset(vo), .sampler_phase_offset(po),
    .decimation_phase_select(dsel), .scan_sample_length(slen), .mismatch_counter_clear(clr),
    .scan_run_control(run), .equalizer_mode(eqm), .equalizer_freeze(frz),
    .scan_done_flag(done), .mismatch_counter(cnt), .eye_boundary_readback(bnd),
    .equalizer_level_readback(lvl), .over_equalized_flag(ovr), .under_equalized_flag(und));
  eyq_chk #(.LANES(2)) i_eyq_chk (.mclk(mclk), .reset(reset), .valid(i_eyq_link_if.valid),
    .link_receiver_enable(rx_en), .scan_mode_select(mode), .scan_sample_length(slen),
    .mismatch_counter_clear(clr), .scan_run_control(run), .equalizer_freeze(frz),
    .scan_done_flag(done), .mismatch_counter(cnt), .equalizer_level_readback(lvl),
    .over_equalized_flag(ovr), .under_equalized_flag(und));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(string nm, logic [CNT_W-1:0] e, logic [CNT_W-1:0] s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    n_errors += notes.size();
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One scan run; boundary note if b, else running count
  task automatic scan(int m, logic [PO_W-1:0] p, logic c, logic b, logic [CNT_W-1:0] e, logic per);
    int i;
    @(posedge mclk);
    #2;
    mode = MODE_W'(m);
    po = p;
    vo = (m >= 8) ? VO_W'(rnd()) : 8'h00;
    dsel = DECIM_W'(rnd() % 20);
    slen = LEN_W'(8 + rnd() % 32);
    clr = c;
    @(posedge mclk);
    #2;
    clr = 0;
    if (c)
      acc = 24'h0;
    if (per)
      acc += CNT_W'(slen);
    notes.push_back(b ? {2'h1, e} : {2'h0, acc});
    run = 1;
    for (i = 0; i < 2000 && done !== 2'h3; i++)
    begin
      @(posedge mclk);
      #1;
    end
    check("done", 24'h3, CNT_W'(done));
    @(posedge mclk);
    #2;
    run = 0;
    repeat (3) @(posedge mclk);
  endtask
  // Freeze, pick equalizer mode, release in a separate write
  task automatic eq(logic [EQM_W-1:0] md, logic [EMPH_W-1:0] p, logic [1:0] f);
    logic [EQ_W-1:0] held;
    @(posedge mclk);
    #2;
    frz = 1;
    pe = p;
    repeat (60) @(posedge mclk);
    #2;
    held = lvl;
    check("eq_frozen_flags", 24'h0, CNT_W'({ovr, und}));
    eqm = md;
    if (md != EQM_ADAPT)
      notes.push_back({2'h2, CNT_W'(f)});
    @(posedge mclk);
    #2;
    check("eq_hold_level", CNT_W'(held), CNT_W'(lvl));
    frz = 0;
    repeat (200) @(posedge mclk);
    #2;
    if (md == EQM_ADAPT)
      check("eq_resume", 24'h1, CNT_W'(lvl != held));
    else
      check("eq_in_time", CNT_W'(f), CNT_W'({ovr, und}));
    repeat (200) @(posedge mclk);
  endtask
  // Monitor: oldest note against each new result
  always @(posedge mclk)
  begin
    eyq_note_t n;
    #1;
    if (done[0] === 1'b1 && done_p === 1'b0 && notes.size() > 0)
    begin
      n = notes.pop_front();
      check("lane0", n.val, n.kind[0] ? CNT_W'(bnd[0]) : cnt[0]);
      check("lane1", n.val, n.kind[0] ? CNT_W'(bnd[1]) : cnt[1]);
    end
    if ((ovr | und) === 1'b1 && flg_p === 1'b0 && notes.size() > 0)
    begin
      n = notes.pop_front();
      check("eq_flags", n.val, CNT_W'({ovr, und}));
    end
    done_p = done[0];
    flg_p = ovr | und;
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    #2;
    reset = 0;
    eqm = EQM_ADAPT;
    tx_en = 1;
    repeat (4) @(posedge mclk);
    #2;
    check("eq_level", CNT_W'(EQ_LEVEL_RST), CNT_W'(lvl));
    rx_en = 1;
    repeat (100) @(posedge mclk);
    scan(1, 2'h1, 1'b1, 1'b0, 24'h0, 1'b1);
    scan(1, 2'h1, 1'b0, 1'b0, 24'h0, 1'b1);
    for (int m = 0; m < 16; m++)
      if (m != 1)
        scan(m, 2'h1, 1'b1, m inside {8, 9, 10}, (m == 10) ? 24'h27 : 24'h28, 1'b0);
    #2;
    pat = 1;
    scan(0, 2'h0, 1'b1, 1'b0, 24'h0, 1'b1);
    #2;
    pat = 0;
    eq(EQM_PRE, 4'hC, 2'h1);
    eq(EQM_POST, 4'hF, 2'h2);
    eq(EQM_POST, 4'h0, 2'h1);
    eq(EQM_ADAPT, 4'hF, 2'h0);
    complete_run();
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
endmodule
